// File: bench/tpcg_cpu_model.sv
// Processor-side model that flags machine-cycle starts
`timescale 1ns/10ps
`default_nettype none
module tpcg_cpu_model
(
  input  wire logic clk,
  input  wire logic phase1,
  input  wire logic phase2,
  input  wire logic want,
  input  wire logic stray,
  output var  logic cycle_start
);
  initial cycle_start = 1'b0;
  // Stray mode flags in phase one, where the flag must be ignored
  always @(negedge clk)
    cycle_start <= want && (stray ? phase1 : phase2);
endmodule : tpcg_cpu_model
`default_nettype wire

// File: bench/tpcg_gen_bench.sv
// Self-checking bench for the two-phase clock generator
`timescale 1ns/10ps
`default_nettype none
module tpcg_gen_bench;
  import tpcg_pkg::*;
  logic       clk, rstn, rdy_in, rst_in, cyc, want, stray, odd, v;
  logic       p1, p2, p2t, osc, stb_n, rdy, rst_o, btick, seen, p1_d;
  logic       rdy_d, rst_d, en;
  logic [3:0] snap;
  logic [2:0] trim;
  int         err_total, num_checks, cyc_n, last_b;
  logic       exp_q[$], rdy_q[$], rst_q[$];
  int         baud_q[$];

  tpcg_gen dut (.clk(clk), .rstn(rstn), .clk_en(en),
    .reset_request_in(rst_in), .ready_request_in(rdy_in),
    .cycle_start(cyc), .baud_trim_sel(trim), .baud_odd_rate(odd),
    .phase1(p1), .phase2(p2), .phase2_ttl(p2t), .osc_out(osc),
    .status_strobe_n(stb_n), .ready(rdy), .reset_out(rst_o),
    .baud_tick(btick));
  tpcg_cpu_model cpu (.clk(clk), .phase1(p1), .phase2(p2), .want(want),
    .stray(stray), .cycle_start(cyc));

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("ERROR %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk

  task automatic results;
    if (err_total == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : results

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cyc_n++;
    if (cyc_n == 80000)
    begin
      err_total++;
      results();
    end
  end

  // Result watcher: compares each output event with the oldest note
  always @(negedge clk)
    if (rstn)
    begin
      if (!stb_n)
        seen = 1'b1;
      if (p1 && !p1_d)
      begin
        if (exp_q.size() > 0)
          chk("strobe", exp_q.pop_front(), seen);
        seen = 1'b0;
      end
      p1_d = p1;
      if (rdy !== rdy_d)
        chk("ready", rdy_q.size() ? rdy_q.pop_front() : rdy_d, rdy);
      if (rst_o !== rst_d)
        chk("reset", rst_q.size() ? rst_q.pop_front() : rst_d, rst_o);
      rdy_d = rdy;
      rst_d = rst_o;
      if (btick)
      begin
        if (baud_q.size() > 0)
          chk("baud", baud_q.pop_front(), cyc_n - last_b);
        last_b = cyc_n;
      end
    end

  task automatic cyc_begin;
    do @(negedge clk); while (p1);
    do @(negedge clk); while (!p1);
  endtask : cyc_begin

  task automatic wt_tick;
    do @(negedge clk); while (!btick);
    @(negedge clk);
  endtask : wt_tick

  initial
  begin
    {rstn, rdy_in, want, stray, odd, seen, p1_d, rdy_d} = '0;
    {rst_in, rst_d, en} = 3'b111;
    trim = 3'h0;
    {err_total, num_checks, cyc_n, last_b} = '0;
    void'($urandom(25071));
    repeat (20) @(negedge clk);
    rstn = 1'b1;
    @(negedge clk);
    chk("strobe idle", 1'b1, stb_n);
    chk("ready rst", 1'b0, rdy);
    chk("reset rst", 1'b1, rst_o);
    repeat (40)
    begin
      cyc_begin();
      want <= 1'($urandom);
      stray <= 1'($urandom);
      do @(negedge clk); while (!p2);
      exp_q.push_back(want && !stray);
      repeat (2) @(negedge clk);
      v = 1'($urandom);
      if (v !== rdy_in)
        rdy_q.push_back(v);
      rdy_in = v;
      v = 1'($urandom);
      if (v !== rst_in)
        rst_q.push_back(v);
      rst_in = v;
    end
    want <= 1'b0;
    repeat (2) cyc_begin();
    chk("pending", 0, exp_q.size() + rdy_q.size() + rst_q.size());
    // Clock enable low must hold phase one, phase two, oscillator and strobe where they stand
    en = 1'b0;
    @(negedge clk);
    snap = {p1, p2, osc, stb_n};
    repeat (8) @(negedge clk);
    chk("freeze", snap, {p1, p2, osc, stb_n});
    en = 1'b1;
    for (int k = 0; k < 9; k++)
    begin
      odd = (k == 8);
      trim = 3'(k);
      wt_tick();
      baud_q.push_back(k == 8 ? OSC_TICKS * BASIC_DIV * (1 << ODD_TAP)
                       * ODD_DIV : (OSC_TICKS * BASIC_DIV) << k);
      wt_tick();
    end
    chk("baud left", 0, baud_q.size());
    results();
  end
endmodule : tpcg_gen_bench
`default_nettype wire

// File: bench/tpcg_gen_monitor.sv
// Timing checker for the two-phase clock generator ports
`timescale 1ns/10ps
`default_nettype none
module tpcg_gen_monitor
  import tpcg_pkg::*;
(
  input wire logic       clk,
  input wire logic       rstn,
  input wire logic       clk_en,
  input wire logic       reset_request_in,
  input wire logic       ready_request_in,
  input wire logic       cycle_start,
  input wire logic [2:0] baud_trim_sel,
  input wire logic       baud_odd_rate,
  input wire logic       phase1,
  input wire logic       phase2,
  input wire logic       phase2_ttl,
  input wire logic       osc_out,
  input wire logic       status_strobe_n,
  input wire logic       ready,
  input wire logic       reset_out,
  input wire logic       baud_tick
);
  logic warm_r;

  default clocking @(posedge clk); endclocking
  // A low clock enable freezes all timing, so checks pause with it
  default disable iff (!rstn || !clk_en);

  // The first cycle after reset may be short, so phase one checks wait
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
      warm_r <= 1'b0;
    else if (phase2)
      warm_r <= 1'b1;

  a_ph1_width: assert property (
    warm_r && $rose(phase1) |=> phase1[*3] ##1 !phase1)
    else $error("phase one width wrong");
  a_ph2_width: assert property (
    $rose(phase2) |=> phase2[*8] ##1 phase2 ##1 !phase2)
    else $error("phase two width wrong");
  a_phase_gap: assert property (
    $fell(phase2) |-> !phase1[*4] ##1 phase1)
    else $error("gap before phase one wrong");
  a_no_overlap: assert property (!(phase1 && phase2))
    else $error("phases overlap");
  a_ph_lead: assert property (
    warm_r && $rose(phase1) |-> ##4 $rose(phase2))
    else $error("phase two lead wrong");
  a_cycle_len: assert property (
    warm_r && $rose(phase1) |-> ##18 $rose(phase1))
    else $error("clock period wrong");
  a_ttl_copy: assert property (phase2_ttl == phase2)
    else $error("phase two copy differs");
  a_osc_toggle: assert property (
    $past(rstn) && $past(clk_en) |-> osc_out != $past(osc_out))
    else $error("oscillator output not toggling");
  a_stb_place: assert property (
    $fell(status_strobe_n) |-> ##2 $rose(phase1))
    else $error("strobe misplaced");
  a_stb_width: assert property (
    $fell(status_strobe_n) |=> !status_strobe_n ##1 status_strobe_n)
    else $error("strobe width wrong");
  a_sync_edge: assert property (
    $changed(ready) || $changed(reset_out) |-> $fell(phase2))
    else $error("ready or reset changed off time");
endmodule : tpcg_gen_monitor

bind tpcg_gen tpcg_gen_monitor u_mon (.clk, .rstn, .clk_en,
  .reset_request_in, .ready_request_in, .cycle_start, .baud_trim_sel,
  .baud_odd_rate, .phase1, .phase2, .phase2_ttl, .osc_out,
  .status_strobe_n, .ready, .reset_out, .baud_tick);
`default_nettype wire

// File: rtl/tpcg_baud.sv
// Baud-rate divider fed from the oscillator period tick
`timescale 1ns/10ps
`default_nettype none
module tpcg_baud
  import tpcg_pkg::*;
#(
  parameter int unsigned BASIC = BASIC_DIV,
  parameter int unsigned TW    = TRIM_W,
  parameter int unsigned ODD   = ODD_DIV,
  parameter int unsigned TAP   = ODD_TAP
)
(
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       clk_en,
  input  wire logic       osc_tick,
  input  wire logic [2:0] trim_sel,
  input  wire logic       odd_rate,
  output logic            baud_tick
);

  typedef struct packed {
    logic [7:0]    basic_cnt;
    logic [TW-1:0] trim_cnt;
    logic [3:0]    odd_cnt;
    logic          tick;
  } tpcg_baud_s;

  if (BASIC < 2 || BASIC > 256 || TW < 1 || TW > 7 || ODD < 2 ||
      ODD > 16 || TAP >= TW)
  begin : g_bad_params
    $error("tpcg_baud: unsupported divider parameters");
  end

  tpcg_baud_s st_r;
  tpcg_baud_s st_nxt;

  // Trim tap k fires when the low k trim bits are all ones
  function automatic logic tap_hit(input logic [TW-1:0] c,
                                   input logic [2:0] k);
    logic [TW-1:0] mask;
    mask = TW'((8'h01 << k) - 8'h01);
    tap_hit = ((c & mask) == mask);
  endfunction : tap_hit

  always_comb
  begin
    logic base;
    base = 1'b0;
    st_nxt = st_r;
    st_nxt.tick = 1'b0;
    if (osc_tick)
    begin
      if (st_r.basic_cnt == 8'(BASIC - 1))
      begin
        st_nxt.basic_cnt = 8'h00;
        base = 1'b1;
      end
      else
        st_nxt.basic_cnt = st_r.basic_cnt + 8'h01;
    end
    if (base)
    begin
      st_nxt.trim_cnt = st_r.trim_cnt + TW'(1);
      if (odd_rate)
      begin
        // Odd rate: divide the 1200-rate tap by ODD
        if (tap_hit(st_r.trim_cnt, 3'(TAP)))
        begin
          if (st_r.odd_cnt == 4'(ODD - 1))
          begin
            st_nxt.odd_cnt = 4'h0;
            st_nxt.tick = 1'b1;
          end
          else
            st_nxt.odd_cnt = st_r.odd_cnt + 4'h1;
        end
      end
      else
        st_nxt.tick = tap_hit(st_r.trim_cnt, trim_sel);
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      st_r <= '0;
    else if (clk_en)
      st_r <= st_nxt;
  end

  assign baud_tick = st_r.tick;

endmodule : tpcg_baud
`default_nettype wire

// File: rtl/tpcg_gen.sv
// Two-phase non-overlapping clock generator with ready and reset sync
//
// Behaviour
// - Phase one is high for two of nine oscillator periods.
// - Phase two is high for five of nine oscillator periods.
// - Two oscillator periods separate phase two fall from phase one rise.
// - Phase two rises two oscillator periods after phase one rises.
// - Strobe falls six periods after phase two rises in cycle-start cycles.
// - Strobe stays low for one oscillator period, then returns high.
// - Strobe output is active low and rests high.
// - Ready request passes a synchronizer before driving ready output.
// - Ready and reset outputs change four periods before phase two rises.
// - Reset output follows reset request, synchronized like ready.
// - A logic-level copy of phase two is driven.
// - Oscillator output is a symmetric square wave at crystal rate.
// - One processor clock period is nine oscillator periods.
// - Baud divider divides by the basic factor then a power-of-two trim.
// - Odd rate divides the 1200-rate tap by eleven.
`timescale 1ns/10ps
`default_nettype none
module tpcg_gen
  import tpcg_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       clk_en,
  input  wire logic       reset_request_in,
  input  wire logic       ready_request_in,
  input  wire logic       cycle_start,
  input  wire logic [2:0] baud_trim_sel,
  input  wire logic       baud_odd_rate,
  output logic            phase1,
  output logic            phase2,
  output logic            phase2_ttl,
  output logic            osc_out,
  output logic            status_strobe_n,
  output logic            ready,
  output logic            reset_out,
  output logic            baud_tick
);

  tpcg_state_s st_r;
  tpcg_state_s st_nxt;

  // Refuse timing constants the counter or the windows cannot serve;
  // the oscillator output toggles every tick, so a period is two ticks
  if (TICKS_PER_CYC > (1 << CNT_W) ||
      OSC_TICKS != 2 ||
      OSC_PER_CYCLE > 15 ||
      PH1_START + PH1_LEN != PH2_START ||
      PH2_START + PH2_LEN + GAP_LEN != OSC_PER_CYCLE ||
      STB_POS + STB_LEN > OSC_PER_CYCLE ||
      SYNC_OUT_POS >= OSC_PER_CYCLE)
  begin : g_bad_timing
    $error("tpcg_gen: unsupported timing constants");
  end

  // Oscillator period index 0..8 within the processor clock period
  function automatic logic [3:0] osc_pos(input logic [CNT_W-1:0] c);
    osc_pos = 4'(c / OSC_TICKS);
  endfunction : osc_pos

  function automatic logic in_win(input logic [3:0] p,
                                  input logic [3:0] start,
                                  input logic [3:0] len);
    in_win = (p >= start) && (p < start + len);
  endfunction : in_win

  always_comb
  begin
    logic [3:0] pos_nxt;
    logic       period_edge;
    pos_nxt = 4'h0;
    period_edge = 1'b0;
    st_nxt = st_r;

    // Pin synchronizers: three stages, a change counts once 2 and 3 agree
    st_nxt.pins.rdy_pipe = {st_r.pins.rdy_pipe[1:0], ready_request_in};
    st_nxt.pins.rst_pipe = {st_r.pins.rst_pipe[1:0], reset_request_in};
    if (st_r.pins.rdy_pipe[1] == st_r.pins.rdy_pipe[2])
      st_nxt.pins.rdy_clean = st_r.pins.rdy_pipe[2];
    if (st_r.pins.rst_pipe[1] == st_r.pins.rst_pipe[2])
      st_nxt.pins.rst_clean = st_r.pins.rst_pipe[2];

    // Single cycle counter: nine oscillator periods of OSC_TICKS each
    if (st_r.cnt == CNT_LAST)
      st_nxt.cnt = '0;
    else
      st_nxt.cnt = st_r.cnt + CNT_W'(1);
    pos_nxt = osc_pos(st_nxt.cnt);
    period_edge = (st_nxt.cnt % OSC_TICKS) == 0;

    st_nxt.osc = ~st_r.osc;
    st_nxt.osc_tick = period_edge;

    st_nxt.phase1 = in_win(pos_nxt, PH1_START, PH1_LEN);
    st_nxt.phase2 = in_win(pos_nxt, PH2_START, PH2_LEN);
    st_nxt.phase2_ttl = st_nxt.phase2;

    // Catch cycle start while phase two is high
    if (pos_nxt == PH2_START && period_edge)
      st_nxt.sync_seen = 1'b0;
    if (st_r.phase2 && cycle_start)
      st_nxt.sync_seen = 1'b1;

    st_nxt.strobe_n = ~(st_nxt.sync_seen &&
                        in_win(pos_nxt, STB_POS, STB_LEN));

    // Outputs move only at the period four ahead of the next phase two rise
    if (pos_nxt == SYNC_OUT_POS && period_edge)
    begin
      st_nxt.ready = st_r.pins.rdy_clean;
      st_nxt.reset = st_r.pins.rst_clean;
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_r <= '0;
      st_r.strobe_n <= 1'b1;
      st_r.ready <= READY_RST;
      st_r.reset <= RESET_OUT_RST;
      st_r.pins.rst_clean <= RESET_OUT_RST;
      st_r.pins.rst_pipe <= 3'h7;
    end
    else if (clk_en)
      st_r <= st_nxt;
  end

  tpcg_baud u_baud (
    .clk       (clk),
    .rstn      (rstn),
    .clk_en    (clk_en),
    .osc_tick  (st_r.osc_tick),
    .trim_sel  (baud_trim_sel),
    .odd_rate  (baud_odd_rate),
    .baud_tick (baud_tick)
  );

  assign phase1          = st_r.phase1;
  assign phase2          = st_r.phase2;
  assign phase2_ttl      = st_r.phase2_ttl;
  assign osc_out         = st_r.osc;
  assign status_strobe_n = st_r.strobe_n;
  assign ready           = st_r.ready;
  assign reset_out       = st_r.reset;

endmodule : tpcg_gen
`default_nettype wire

// File: rtl/tpcg_pkg.sv
// Shared constants and carrier types of the two-phase clock generator
package tpcg_pkg;

  // Clock ticks per oscillator period; the oscillator output toggles each tick
  localparam int unsigned CLK_HZ         = 40000000;
  localparam int unsigned OSC_TICKS      = 2;
  localparam int unsigned OSC_PER_CYCLE  = 9;
  localparam int unsigned TICKS_PER_CYC  = OSC_TICKS * OSC_PER_CYCLE;
  localparam int unsigned CNT_W          = 5;

  // Oscillator-period positions inside one processor clock period
  localparam logic [3:0] PH1_START       = 4'h0;
  localparam logic [3:0] PH1_LEN         = 4'h2;
  localparam logic [3:0] PH2_START       = 4'h2;
  localparam logic [3:0] PH2_LEN         = 4'h5;
  localparam logic [3:0] GAP_LEN         = 4'h2;
  localparam logic [3:0] STB_DELAY       = 4'h6;
  localparam logic [3:0] STB_LEN         = 4'h1;
  localparam logic [3:0] SYNC_OUT_DELAY  = 4'h4;
  localparam logic [3:0] STB_POS         = PH2_START + STB_DELAY;
  localparam logic [3:0] SYNC_OUT_POS    = OSC_PER_CYCLE[3:0] + PH2_START
                                           - SYNC_OUT_DELAY;
  localparam logic [CNT_W-1:0] CNT_LAST  = CNT_W'(TICKS_PER_CYC - 1);

  // Reset values
  localparam logic READY_RST     = 1'b0;
  localparam logic RESET_OUT_RST = 1'b1;

  // Baud divider defaults
  localparam int unsigned BASIC_DIV = 30;
  localparam int unsigned TRIM_W    = 7;
  localparam int unsigned ODD_DIV   = 11;
  localparam int unsigned ODD_TAP   = 3;

  typedef struct packed {
    logic [2:0] rdy_pipe;
    logic [2:0] rst_pipe;
    logic       rdy_clean;
    logic       rst_clean;
  } tpcg_sync_s;

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             phase1;
    logic             phase2;
    logic             phase2_ttl;
    logic             osc;
    logic             osc_tick;
    logic             strobe_n;
    logic             sync_seen;
    logic             ready;
    logic             reset;
    tpcg_sync_s       pins;
  } tpcg_state_s;

endpackage : tpcg_pkg
